// [logic/sensor_cfg.svh]
`ifndef SENSOR_CFG_SVH
`define SENSOR_CFG_SVH

// Register offsets on the two-wire bus
`define ADDR_INT_CTRL   8'h89
`define ADDR_LOW_HI     8'h8a
`define ADDR_LOW_LO     8'h8b
`define ADDR_HIGH_HI    8'h8c
`define ADDR_HIGH_LO    8'h8d
`define ADDR_FLAGS      8'h8e
`define ADDR_MOD        8'h8f
`define ADDR_AMB_IR     8'h90

// Reset values
`define MOD_RESET       8'h01
`define FLAGS_RESET     8'h00
`define CTRL_RESET      8'h00
`define TH_RESET        16'h0000
`define ZERO_BYTE       8'h00

// Event flag positions
`define FLAG_PROX       3
`define FLAG_ALS        2
`define FLAG_LOW        1
`define FLAG_HIGH       0
`define FLAGS_MASK      8'h0f

// Interrupt control positions
`define CTRL_PROX_EN    3
`define CTRL_ALS_EN     2
`define CTRL_LIMIT_EN   1
`define CTRL_LIMIT_SEL  0
`define CTRL_MASK       8'hef

// Modulator timing fields
`define MOD_DELAY       7:5
`define MOD_FREQ        4:3
`define MOD_DEAD        2:0

// Serial target
`define TARGET_ADDR     7'h13
`define BIT_COUNT       4'h8

`endif

// [logic/sensor_pkg.sv]
package sensor_pkg;

    // Serial target states
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_ADDR     = 3'b001,
        ST_ACK_ADDR = 3'b010,
        ST_WRITE    = 3'b011,
        ST_ACK_WR   = 3'b100,
        ST_READ     = 3'b101,
        ST_ACK_RD   = 3'b110
    } link_state_t;

endpackage : sensor_pkg

// [logic/two_wire_target.sv]
`include "sensor_cfg.svh"

module two_wire_target
    import sensor_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `TARGET_ADDR
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    // Bus pins
    input  wire logic       scl_pin,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // Register access
    output logic            wr_stb,
    output logic [7:0]      wr_addr,
    output logic [7:0]      wr_data,
    output logic [7:0]      rd_addr,
    input  wire logic [7:0] rd_data
);

    logic        scl_meta, scl_sync, scl_prev;
    logic        sda_meta, sda_sync, sda_prev;
    logic        scl_rise, scl_fall, start_seen, stop_seen;
    link_state_t state_reg, state_next;
    logic [3:0]  bits_reg, bits_next;
    logic [7:0]  shift_reg, shift_next;
    logic [7:0]  ptr_reg, ptr_next;
    logic        first_reg, first_next;
    logic        read_reg, read_next;
    logic        oe_reg, oe_next;
    logic        stb_reg, stb_next;

    // Two-stage synchronisers; the first stage feeds only the second
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_meta <= scl_pin;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
        end
    end

    // Edges and bus conditions
    assign scl_rise   = scl_sync & ~scl_prev;
    assign scl_fall   = ~scl_sync & scl_prev;
    assign start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
    assign stop_seen  = scl_sync & scl_prev & ~sda_prev & sda_sync;

    // Bit-level sequencing; data changes only after a falling clock
    always_comb begin
        state_next = state_reg;
        bits_next  = bits_reg;
        shift_next = shift_reg;
        ptr_next   = ptr_reg;
        first_next = first_reg;
        read_next  = read_reg;
        oe_next    = oe_reg;
        stb_next   = 1'b0;
        if (start_seen) begin
            state_next = ST_ADDR;
            bits_next  = 4'h0;
            oe_next    = 1'b0;
            first_next = 1'b1;
        end else if (stop_seen) begin
            state_next = ST_IDLE;
            oe_next    = 1'b0;
        end else begin
            case (state_reg)
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_sync};
                        bits_next  = bits_reg + 4'h1;
                    end else if (scl_fall && bits_reg == `BIT_COUNT) begin
                        bits_next = 4'h0;
                        if (state_reg == ST_ADDR) begin
                            if (shift_reg[7:1] == DEV_ADDR) begin
                                oe_next    = 1'b1;
                                read_next  = shift_reg[0];
                                state_next = ST_ACK_ADDR;
                            end else begin
                                state_next = ST_IDLE;
                            end
                        end else begin
                            oe_next    = 1'b1;
                            state_next = ST_ACK_WR;
                            if (first_reg) begin
                                ptr_next = shift_reg;
                            end else begin
                                stb_next = 1'b1;
                            end
                        end
                    end
                end
                ST_ACK_ADDR, ST_ACK_RD: begin
                    if (state_reg == ST_ACK_RD && scl_rise && sda_sync) begin
                        state_next = ST_IDLE; // Master said no more
                    end else if (scl_fall) begin
                        if (read_reg) begin
                            shift_next = rd_data;
                            oe_next    = ~rd_data[7];
                            bits_next  = 4'h1;
                            state_next = ST_READ;
                        end else begin
                            oe_next    = 1'b0;
                            state_next = ST_WRITE;
                        end
                    end
                end
                ST_ACK_WR: begin
                    if (scl_fall) begin
                        oe_next    = 1'b0;
                        state_next = ST_WRITE;
                        first_next = 1'b0;
                        if (!first_reg) begin
                            ptr_next = ptr_reg + 8'h01;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        if (bits_reg == `BIT_COUNT) begin
                            oe_next    = 1'b0;
                            ptr_next   = ptr_reg + 8'h01;
                            state_next = ST_ACK_RD;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_next    = ~shift_reg[6];
                            bits_next  = bits_reg + 4'h1;
                        end
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            bits_reg  <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg   <= 8'h00;
            first_reg <= 1'b1;
            read_reg  <= 1'b0;
            oe_reg    <= 1'b0;
            stb_reg   <= 1'b0;
            sda_out   <= 1'b0;
        end else begin
            state_reg <= state_next;
            bits_reg  <= bits_next;
            shift_reg <= shift_next;
            ptr_reg   <= ptr_next;
            first_reg <= first_next;
            read_reg  <= read_next;
            oe_reg    <= oe_next;
            stb_reg   <= stb_next;
            sda_out   <= 1'b0; // Open drain only ever pulls low
        end
    end

    assign sda_oe  = oe_reg;
    assign wr_stb  = stb_reg;
    assign wr_addr = ptr_reg;
    assign wr_data = shift_reg;
    assign rd_addr = ptr_reg;

endmodule : two_wire_target

// [logic/sensor_irq_status_modulator_cfg.sv]
// Contract
// - Status register holds four event flags
// - Flags sticky, cleared by writing one
// - Interrupt pin low while any flag set
// - Flag set only when its enable set
// - Source select: zero proximity, one light
// - Sixteen-bit limits; crossings set limit flags
// - Timing register: delay, frequency, dead time
// - Delay field lags evaluation, resets zero
// - Dead time blanks edges, resets one
// - No measurement demand means standby
// - Standby keeps emitter sink off
`include "sensor_cfg.svh"

module sensor_irq_status_modulator_cfg
    import sensor_pkg::*;
#(
    parameter int         TH_W     = 16,
    parameter logic [6:0] DEV_ADDR = `TARGET_ADDR
) (
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            nrst,
    // Two-wire bus pins
    input  wire logic            scl_pin,
    input  wire logic            sda_in,
    output logic                 sda_out,
    output logic                 sda_oe,
    // Interrupt pin, pulled low while enabled
    output logic                 int_oe,
    // Measurement results and events
    input  wire logic            prox_ready_evt,
    input  wire logic            als_ready_evt,
    input  wire logic [TH_W-1:0] prox_result,
    input  wire logic [TH_W-1:0] als_result,
    // Measurement demands
    input  wire logic            prox_demand,
    input  wire logic            als_demand,
    input  wire logic            led_demand,
    // Power and emitter control
    output logic                 standby,
    output logic                 led_sink_on,
    // Modulator timing
    output logic [2:0]           delay_time,
    output logic [1:0]           prox_freq,
    output logic [2:0]           dead_time
);

    logic            wr_stb;
    logic [7:0]      wr_addr, wr_data, rd_addr;
    logic [7:0]      rd_data;
    logic [7:0]      ctrl_reg, ctrl_next;
    logic [TH_W-1:0] low_th_reg, low_th_next;
    logic [TH_W-1:0] high_th_reg, high_th_next;
    logic [7:0]      flags_reg, flags_next;
    logic [7:0]      mod_reg, mod_next;
    logic [7:0]      clr_bits, set_bits;
    logic            int_oe_reg, int_oe_next;
    logic            standby_reg, standby_next;
    logic            sink_reg, sink_next;
    logic            limit_evt;
    logic [TH_W-1:0] limit_val;
    logic [1:0]      limit_hit;

    // Serial target carrying all register traffic
    two_wire_target #(
        .DEV_ADDR (DEV_ADDR)
    ) u_target (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .scl_pin (scl_pin),
        .sda_in  (sda_in),
        .sda_out (sda_out),
        .sda_oe  (sda_oe),
        .wr_stb  (wr_stb),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    // Low and high crossings as {below, above}
    function automatic logic [1:0] limit_cmp(input logic [TH_W-1:0] val,
                                             input logic [TH_W-1:0] lo,
                                             input logic [TH_W-1:0] hi);
        limit_cmp = {(val < lo), (val > hi)};
    endfunction : limit_cmp

    assign limit_evt = ctrl_reg[`CTRL_LIMIT_SEL] ? als_ready_evt : prox_ready_evt;
    assign limit_val = ctrl_reg[`CTRL_LIMIT_SEL] ? als_result : prox_result;
    assign limit_hit = limit_cmp(limit_val, low_th_reg, high_th_reg);

    always_comb begin
        set_bits             = 8'h00;
        set_bits[`FLAG_PROX] = prox_ready_evt & ctrl_reg[`CTRL_PROX_EN];
        set_bits[`FLAG_ALS]  = als_ready_evt & ctrl_reg[`CTRL_ALS_EN];
        set_bits[`FLAG_LOW]  = limit_evt & ctrl_reg[`CTRL_LIMIT_EN] & limit_hit[1];
        set_bits[`FLAG_HIGH] = limit_evt & ctrl_reg[`CTRL_LIMIT_EN] & limit_hit[0];
    end

    // Register writes, flag update and pin levels
    always_comb begin
        ctrl_next    = ctrl_reg;
        low_th_next  = low_th_reg;
        high_th_next = high_th_reg;
        mod_next     = mod_reg;
        clr_bits     = 8'h00;
        if (wr_stb) begin
            if (wr_addr == `ADDR_INT_CTRL) begin
                ctrl_next = wr_data & `CTRL_MASK;
            end else if (wr_addr == `ADDR_LOW_HI) begin
                low_th_next[15:8] = wr_data; // High byte sits lower
            end else if (wr_addr == `ADDR_LOW_LO) begin
                low_th_next[7:0] = wr_data;
            end else if (wr_addr == `ADDR_HIGH_HI) begin
                high_th_next[15:8] = wr_data;
            end else if (wr_addr == `ADDR_HIGH_LO) begin
                high_th_next[7:0] = wr_data;
            end else if (wr_addr == `ADDR_FLAGS) begin
                clr_bits = wr_data & `FLAGS_MASK;
            end else if (wr_addr == `ADDR_MOD) begin
                mod_next = wr_data;
            end
        end
        flags_next   = ((flags_reg & ~clr_bits) | set_bits) & `FLAGS_MASK;
        int_oe_next  = |flags_next;
        standby_next = ~(prox_demand | als_demand);
        sink_next    = led_demand & ~standby_next;
    end

    // Control and status registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg    <= `CTRL_RESET;
            low_th_reg  <= `TH_RESET;
            high_th_reg <= `TH_RESET;
            flags_reg   <= `FLAGS_RESET;
            mod_reg     <= `MOD_RESET;
            int_oe_reg  <= 1'b0;
            standby_reg <= 1'b1;
            sink_reg    <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            low_th_reg  <= low_th_next;
            high_th_reg <= high_th_next;
            flags_reg   <= flags_next;
            mod_reg     <= mod_next;
            int_oe_reg  <= int_oe_next;
            standby_reg <= standby_next;
            sink_reg    <= sink_next;
        end
    end

    // Read mux; reserved and unmapped offsets read zero
    always_comb begin
        rd_data = `ZERO_BYTE;
        if (rd_addr == `ADDR_INT_CTRL) begin
            rd_data = ctrl_reg;
        end else if (rd_addr == `ADDR_LOW_HI) begin
            rd_data = low_th_reg[15:8];
        end else if (rd_addr == `ADDR_LOW_LO) begin
            rd_data = low_th_reg[7:0];
        end else if (rd_addr == `ADDR_HIGH_HI) begin
            rd_data = high_th_reg[15:8];
        end else if (rd_addr == `ADDR_HIGH_LO) begin
            rd_data = high_th_reg[7:0];
        end else if (rd_addr == `ADDR_FLAGS) begin
            rd_data = flags_reg & `FLAGS_MASK;
        end else if (rd_addr == `ADDR_MOD) begin
            rd_data = mod_reg;
        end
    end

    // Outputs straight from registers
    assign int_oe      = int_oe_reg;
    assign standby     = standby_reg;
    assign led_sink_on = sink_reg;
    assign prox_freq   = mod_reg[`MOD_FREQ];
    assign dead_time   = mod_reg[`MOD_DEAD];
    assign delay_time  = mod_reg[`MOD_DELAY];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    sequence s_flags_write(int b);
        wr_stb && wr_addr == `ADDR_FLAGS && wr_data[b];
    endsequence

    a_pin_tracks_flags:
        assert property (int_oe == (flags_reg != 8'h00))
        else $error("interrupt pin disagrees with flags");
    a_upper_bits_zero:
        assert property (flags_reg[7:4] == 4'h0)
        else $error("upper flag bits not zero");
    a_flag_stays_set:
        assert property (flags_reg[`FLAG_PROX]
                         && !(wr_stb && wr_addr == `ADDR_FLAGS && wr_data[`FLAG_PROX])
                         |=> flags_reg[`FLAG_PROX])
        else $error("proximity flag dropped without clear");
    a_one_clears_flag:
        assert property (s_flags_write(`FLAG_ALS) ##0 !als_ready_evt
                         |=> !flags_reg[`FLAG_ALS])
        else $error("write one did not clear flag");
    a_disabled_no_set:
        assert property (!ctrl_reg[`CTRL_PROX_EN] && !flags_reg[`FLAG_PROX]
                         |=> !flags_reg[`FLAG_PROX])
        else $error("flag set while disabled");
    a_event_sets_flag:
        assert property (prox_ready_evt && ctrl_reg[`CTRL_PROX_EN]
                         |=> flags_reg[`FLAG_PROX] && int_oe)
        else $error("enabled event lost");
    a_high_crossing:
        assert property (prox_ready_evt && !ctrl_reg[`CTRL_LIMIT_SEL]
                         && ctrl_reg[`CTRL_LIMIT_EN] && prox_result > high_th_reg
                         |=> flags_reg[`FLAG_HIGH])
        else $error("high crossing not flagged");
    a_light_routing:
        assert property (als_ready_evt && ctrl_reg[`CTRL_LIMIT_SEL]
                         && ctrl_reg[`CTRL_LIMIT_EN] && als_result < low_th_reg
                         |=> flags_reg[`FLAG_LOW])
        else $error("light result not routed to limits");
    a_timing_write:
        assert property (wr_stb && wr_addr == `ADDR_MOD
                         |=> delay_time == $past(wr_data[7:5])
                             && dead_time == $past(wr_data[2:0]))
        else $error("timing fields did not take write");
    a_standby_sink_off:
        assert property (!prox_demand && !als_demand |=> standby && !led_sink_on)
        else $error("emitter on in standby");

endmodule : sensor_irq_status_modulator_cfg

// [bench/two_wire_host.sv]
`include "sensor_cfg.svh"

module two_wire_host (
    // Bus pins seen from the host side
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda_line
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam real        QTR     = 12.0;
    localparam logic [7:0] WR_ADDR = {`TARGET_ADDR, 1'b0};
    localparam logic [7:0] RD_ADDR = {`TARGET_ADDR, 1'b1};

    // Clock stands high and data released between frames
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // One bit time; sample late so a slow device answer is still seen
    task automatic bit_time(output logic seen);
        #(QTR);
        scl = 1'b1;
        #(QTR);
        seen = sda_line;
        #(QTR);
        scl = 1'b0;
        #(QTR);
    endtask : bit_time

    // Start or repeated start: data falls while clock is high
    task automatic start_cond();
        sda_pull = 1'b0;
        #(QTR);
        scl = 1'b1;
        #(2 * QTR);
        sda_pull = 1'b1;
        #(QTR);
        scl = 1'b0;
        #(QTR);
    endtask : start_cond

    // Stop: data rises while clock is high
    task automatic stop_cond();
        sda_pull = 1'b1;
        #(QTR);
        scl = 1'b1;
        #(2 * QTR);
        sda_pull = 1'b0;
        #(4 * QTR);
    endtask : stop_cond

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            sda_pull = ~b[i];
            bit_time(seen);
        end
        sda_pull = 1'b0;
        bit_time(seen);
        ack = ~seen;
    endtask : send_byte

    task automatic recv_byte(output logic [7:0] b);
        logic seen;
        sda_pull = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            bit_time(b[i]);
        end
        // Single-byte reads always end with a not-acknowledge
        bit_time(seen);
    endtask : recv_byte

    // Address the device and set its register pointer; offset ADDR_AMB_IR is refused without a frame
    task automatic select(input logic [7:0] a, output logic ok);
        logic k1;
        logic k2;
        ok = 1'b0;
        if (a == `ADDR_AMB_IR) return;
        start_cond();
        send_byte(WR_ADDR, k1);
        send_byte(a, k2);
        ok = k1 & k2;
    endtask : select

    // host clears flags only by writing ones
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic k;
        select(a, ok);
        send_byte(d, k);
        stop_cond();
        ok = ok & k;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic k;
        select(a, ok);
        start_cond();
        send_byte(RD_ADDR, k);
        recv_byte(d);
        stop_cond();
        ok = ok & k;
    endtask : reg_read
endmodule : two_wire_host

// [bench/sensor_irq_status_modulator_cfg_bench.sv]
`include "sensor_cfg.svh"
`define CHECK(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("BAD %s expected %h seen %h", what, exp, got); \
        end \
    end

module sensor_irq_status_modulator_cfg_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_sys, nrst, scl_pin, sda_pull, sda_out, sda_oe, int_oe;
    logic        prox_ready_evt, als_ready_evt, prox_demand, als_demand, led_demand;
    logic        standby, led_sink_on, ok;
    logic [15:0] prox_result, als_result;
    logic [2:0]  delay_time, dead_time;
    logic [1:0]  prox_freq;
    logic [7:0]  rd, d;
    wire         sda_line;
    int          errors, tests_run, ctrl_m, flags_m, lo_m, hi_m;
    int          seed = 32'hc6de;

    // Pulled-up data line, low when either party pulls
    assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_pull;

    sensor_irq_status_modulator_cfg uut (
        .clk_sys(clk_sys), .nrst(nrst), .scl_pin(scl_pin), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .int_oe(int_oe),
        .prox_ready_evt(prox_ready_evt), .als_ready_evt(als_ready_evt),
        .prox_result(prox_result), .als_result(als_result),
        .prox_demand(prox_demand), .als_demand(als_demand), .led_demand(led_demand),
        .standby(standby), .led_sink_on(led_sink_on), .delay_time(delay_time),
        .prox_freq(prox_freq), .dead_time(dead_time)
    );

    two_wire_host host (.scl(scl_pin), .sda_pull(sda_pull), .sda_line(sda_line));

    // System clock, 5 ns period
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Watchdog so a stuck bus cannot hang the run
    initial begin
        repeat (100000) @(posedge clk_sys);
        errors++;
        report_and_stop();
    end

    task automatic report_and_stop();
        if (errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host.reg_write(a, v, ok);
        `CHECK("write acknowledge", 1'b1, ok)
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input int exp, input string what);
        host.reg_read(a, rd, ok);
        `CHECK("read acknowledge", 1'b1, ok)
        `CHECK(what, exp, rd)
    endtask : rd_chk

    // One event cycle, the reference flags updated alongside
    task automatic fire(input logic [1:0] ev, input logic [15:0] rp, input logic [15:0] ra);
        int   src;
        logic hit;
        @(negedge clk_sys);
        {prox_ready_evt, als_ready_evt} = ev;
        prox_result = rp;
        als_result  = ra;
        src = ctrl_m[0] ? ra : rp;
        hit = ctrl_m[0] ? ev[0] : ev[1];
        if (ev[1] && ctrl_m[3]) flags_m |= 8;
        if (ev[0] && ctrl_m[2]) flags_m |= 4;
        if (hit && ctrl_m[1] && src < lo_m) flags_m |= 2;
        if (hit && ctrl_m[1] && src > hi_m) flags_m |= 1;
        @(negedge clk_sys);
        {prox_ready_evt, als_ready_evt} = 2'b00;
        @(negedge clk_sys);
        `CHECK("interrupt pin", flags_m != 0, int_oe)
    endtask : fire

    initial begin
        nrst = 1'b0;
        {prox_ready_evt, als_ready_evt, prox_demand, als_demand, led_demand} = 5'h00;
        prox_result = 16'h0000;
        als_result  = 16'h0000;
        repeat (10) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        `CHECK("delay time", 3'h0, delay_time)
        `CHECK("frequency", 2'h0, prox_freq)
        `CHECK("dead time", 3'h1, dead_time)
        `CHECK("standby", 1'b1, standby)
        rd_chk(`ADDR_MOD, 8'h01, "timing reset");
        rd_chk(`ADDR_FLAGS, 8'h00, "flags reset");
        // Every frequency code, random delay and dead time
        for (int i = 0; i < 5; i++) begin
            d = (i == 4) ? 8'h01 : $random(seed);
            if (i < 4) d[4:3] = i[1:0];
            wr(`ADDR_MOD, d);
            `CHECK("delay field", d[7:5], delay_time)
            `CHECK("frequency field", d[4:3], prox_freq)
            `CHECK("dead field", d[2:0], dead_time)
            rd_chk(`ADDR_MOD, d, "timing readback");
        end
        // Random limits, enables, events and clears
        flags_m = 0;
        for (int i = 0; i < 12; i++) begin
            lo_m = $random(seed) & 32'hffff;
            hi_m = $random(seed) & 32'hffff;
            wr(`ADDR_LOW_HI, lo_m[15:8]);
            wr(`ADDR_LOW_LO, lo_m[7:0]);
            wr(`ADDR_HIGH_HI, hi_m[15:8]);
            wr(`ADDR_HIGH_LO, hi_m[7:0]);
            d = $random(seed);
            d[1:0] = i[1:0];
            wr(`ADDR_INT_CTRL, d);
            ctrl_m = d & `CTRL_MASK;
            rd_chk(`ADDR_INT_CTRL, ctrl_m, "control readback");
            repeat (3) fire($random(seed), $random(seed), $random(seed));
            rd_chk(`ADDR_FLAGS, flags_m, "flags after events");
            d = $random(seed);
            wr(`ADDR_FLAGS, d);
            flags_m = flags_m & ~d & 32'h0f;
            rd_chk(`ADDR_FLAGS, flags_m, "flags after clear");
            `CHECK("pin after clear", flags_m != 0, int_oe)
        end
        wr(`ADDR_FLAGS, 8'hff);
        `CHECK("pin released", 1'b0, int_oe)
        // Standby and emitter sink over all demand mixes
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_sys);
            {prox_demand, als_demand, led_demand} = i[2:0];
            repeat (2) @(negedge clk_sys);
            `CHECK("standby", ~(i[2] | i[1]), standby)
            `CHECK("emitter sink", i[0] & (i[2] | i[1]), led_sink_on)
        end
        report_and_stop();
    end
endmodule : sensor_irq_status_modulator_cfg_bench
